// ==== logic/core_regs_pkg.sv ====
// core_regs_pkg: bit positions, reset values and encodings for the cpu
// status word and core control word. assumes 16-bit memory-mapped access.
package core_regs_pkg;
   localparam int unsigned WORD_W = 16;

   // =====================================================
   // status word bit positions
   localparam int unsigned ST_WRAP_A   = 15;
   localparam int unsigned ST_WRAP_B   = 14;
   localparam int unsigned ST_CLIP_A   = 13;
   localparam int unsigned ST_CLIP_B   = 12;
   localparam int unsigned ST_ANY_WRAP = 11;
   localparam int unsigned ST_ANY_CLIP = 10;
   localparam int unsigned ST_LOOP     = 9;
   localparam int unsigned ST_HALF_C   = 8;
   localparam int unsigned ST_PRIO_HI  = 7;
   localparam int unsigned ST_PRIO_LO  = 5;
   localparam int unsigned ST_REPEAT   = 4;
   localparam int unsigned ST_NEG      = 3;
   localparam int unsigned ST_SWRAP    = 2;
   localparam int unsigned ST_ZERO     = 1;
   localparam int unsigned ST_CARRY    = 0;

   // =====================================================
   // control word bit positions
   localparam int unsigned CC_VAR_LAT   = 15;
   localparam int unsigned CC_MUL_HI    = 13;
   localparam int unsigned CC_MUL_LO    = 12;
   localparam int unsigned CC_EARLY     = 11;
   localparam int unsigned CC_DEPTH_HI  = 10;
   localparam int unsigned CC_DEPTH_LO  = 8;
   localparam int unsigned CC_CLIP_A    = 7;
   localparam int unsigned CC_CLIP_B    = 6;
   localparam int unsigned CC_CLIP_ST   = 5;
   localparam int unsigned CC_CLIP_W    = 4;
   localparam int unsigned CC_PRIO_MSB  = 3;
   localparam int unsigned CC_FRAME     = 2;
   localparam int unsigned CC_ROUND     = 1;
   localparam int unsigned CC_INT_MUL   = 0;

   // =====================================================
   // reset values
   localparam logic [15:0] STATUS_RESET  = 16'h0000;
   localparam logic [15:0] CONTROL_RESET = 16'h0020;

   // =====================================================
   // encodings
   localparam logic [2:0] PRIO_MASKED = 3'h7;
   localparam logic [1:0] MUL_SIGNED   = 2'h0;
   localparam logic [1:0] MUL_UNSIGNED = 2'h1;
   localparam logic [1:0] MUL_MIXED    = 2'h2;
   localparam logic [1:0] MUL_RESERVED = 2'h3;
endpackage

// ==== logic/alu_flag_calc.sv ====
// alu_flag_calc: forms the alu result flags from operands and result.
// assumes the alu presents operands, result and carries combinationally.
`timescale 1ns/1ps
`default_nettype none
module alu_flag_calc (
   // operation
   input  wire logic        byte_op,
   input  wire logic [15:0] opnd_a,
   input  wire logic [15:0] opnd_b,
   input  wire logic [15:0] result,
   input  wire logic        carry_out,
   input  wire logic        half_carry_out,
   // flags
   output logic             neg_flag,
   output logic             swrap_flag,
   output logic             zero_result,
   output logic             carry_flag,
   output logic             half_flag
);
   logic sign_a;
   logic sign_b;
   logic sign_r;

   assign sign_a      = byte_op ? opnd_a[7] : opnd_a[15];
   assign sign_b      = byte_op ? opnd_b[7] : opnd_b[15];
   assign sign_r      = byte_op ? result[7] : result[15];
   assign neg_flag    = sign_r;
   // same-sign operands giving a different-sign result
   assign swrap_flag  = (sign_a == sign_b) && (sign_r != sign_a);
   assign zero_result = byte_op ? (result[7:0] == 8'h00)
                                : (result == 16'h0000);
   assign carry_flag  = carry_out;
   // the alu reports carry from bit 3 (byte) or bit 7 (word)
   assign half_flag   = half_carry_out;
endmodule
`default_nettype wire

// ==== logic/loop_status_track.sv ====
// loop_status_track: tracks do-loop nesting and the early exit request.
// assumes the loop sequencer pulses enter and leave per loop.
`timescale 1ns/1ps
`default_nettype none
module loop_status_track #(
   parameter int unsigned DEPTH_W = 3
) (
   // clock and reset
   input  wire logic               clk,
   input  wire logic               sys_rst,
   // sequencer events
   input  wire logic               loop_enter,
   input  wire logic               loop_leave,
   input  wire logic               iter_end,
   input  wire logic               exit_req,
   // status
   output logic [DEPTH_W-1:0]      depth,
   output logic                    exit_now
);
   logic [DEPTH_W-1:0] depth_reg;
   logic               exit_pend_reg;

   // depth saturates at both ends so a stray pulse cannot wrap it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         depth_reg <= '0;
      end else if (loop_enter && !loop_leave && depth_reg != '1) begin
         depth_reg <= depth_reg + DEPTH_W'(1);
      end else if (loop_leave && !loop_enter && depth_reg != '0) begin
         depth_reg <= depth_reg - DEPTH_W'(1);
      end
   end

   // a request holds until the current iteration closes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         exit_pend_reg <= 1'b0;
      end else if (exit_req && depth_reg != '0) begin
         exit_pend_reg <= 1'b1;
      end else if (iter_end || depth_reg == '0) begin
         exit_pend_reg <= 1'b0;
      end
   end

   assign depth    = depth_reg;
   assign exit_now = (exit_pend_reg || exit_req) && iter_end
                     && depth_reg != '0;
endmodule
`default_nettype wire

// ==== logic/cpu_status_core_control_regs.sv ====
// cpu_status_core_control_regs: status word and core control word.
// assumes software access as 16-bit word strobes decoded by the core,
// and flag events from alu, dsp and interrupt logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - per-accumulator wrap flag shows current overflow
// - sticky clip flag per accumulator
// - bit 11 ORs wrap flags, clear only
// - bit 10 ORs clip flags, clear only
// - write changes clip flags directly or via bit10
// - bit 9 shows do loop active
// - half carry from bit 3 or 7
// - priority bits 7-5, 111 masks users
// - msb from control bit 3 forms level
// - priority bits read-only when nesting disabled
// - bit 4 shows repeat active
// - negative flag follows result sign
// - signed overflow flag on sign change
// - zero flag sticky, cleared by non-zero
// - carry flag from result msb carry
// - bit 15 variable latency, bit 14 zero
// - multiply sign field decode, 11 reserved
// - early exit ends loop, reads zero
// - bits 10-8 report loop nesting depth
// - bits 7,6 enable accumulator clip, reset 0
// - bit 5 enables store clip, reset 1
// - bit 4 selects 9.31 or 1.31
// - bit 3 set above level 7, clear only
// - bit 2 frame window active, read-only
// - bit 1 selects rounding mode
// - bit 0 selects integer multiply
module cpu_status_core_control_regs (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // software access to the status word
   input  wire logic        status_wr,
   input  wire logic [15:0] status_wdata,
   output logic [15:0]      status_rdata,
   // software access to the control word
   input  wire logic        control_wr,
   input  wire logic [15:0] control_wdata,
   output logic [15:0]      control_rdata,
   // alu result
   input  wire logic        alu_update,
   input  wire logic        alu_byte_op,
   input  wire logic [15:0] alu_opnd_a,
   input  wire logic [15:0] alu_opnd_b,
   input  wire logic [15:0] alu_result,
   input  wire logic        alu_carry_out,
   input  wire logic        alu_half_carry_out,
   // dsp accumulators
   input  wire logic        dsp_acc_a_update,
   input  wire logic        dsp_acc_a_over,
   input  wire logic        dsp_acc_a_sat,
   input  wire logic        dsp_acc_b_update,
   input  wire logic        dsp_acc_b_over,
   input  wire logic        dsp_acc_b_sat,
   // loop sequencer
   input  wire logic        repeat_busy,
   input  wire logic        loop_enter,
   input  wire logic        loop_leave,
   input  wire logic        loop_iter_end,
   input  wire logic        frame_active_in,
   // interrupt logic
   input  wire logic        nesting_disable_ctl,
   input  wire logic        prio_load,
   input  wire logic [3:0]  prio_load_val,
   // decoded controls
   output logic             var_latency_en,
   output logic [1:0]       multiply_sign_mode,
   output logic             mul_mode_reserved,
   output logic             loop_early_exit,
   output logic             clip_enable_acc_a,
   output logic             clip_enable_acc_b,
   output logic             clip_enable_store,
   output logic             clip_width_mode,
   output logic             frame_window_active,
   output logic             round_mode_sel,
   output logic             int_multiply_sel,
   output logic [3:0]       cpu_priority_level,
   output logic             user_irq_masked
);
   // =====================================================
   // state
   logic       acc_a_wrap_flag_reg;
   logic       acc_b_wrap_flag_reg;
   logic       acc_a_clip_sticky_reg;
   logic       acc_b_clip_sticky_reg;
   logic       any_wrap_clr_reg;
   logic       half_carry_flag_reg;
   logic [2:0] prio_reg;
   logic       neg_reg;
   logic       swrap_reg;
   logic       zero_reg;
   logic       carry_reg;
   logic       var_lat_reg;
   logic [1:0] mul_mode_reg;
   logic       clip_a_en_reg;
   logic       clip_b_en_reg;
   logic       clip_st_en_reg;
   logic       clip_w_reg;
   logic       prio_msb_reg;
   logic       round_reg;
   logic       int_mul_reg;

   logic       f_neg;
   logic       f_swrap;
   logic       f_zero;
   logic       f_carry;
   logic       f_half;
   logic [2:0] nest_depth;
   logic       any_wrap;
   logic       any_clip;
   logic       early_req;

   alu_flag_calc i_alu_flag_calc (
      .byte_op        (alu_byte_op),
      .opnd_a         (alu_opnd_a),
      .opnd_b         (alu_opnd_b),
      .result         (alu_result),
      .carry_out      (alu_carry_out),
      .half_carry_out (alu_half_carry_out),
      .neg_flag       (f_neg),
      .swrap_flag     (f_swrap),
      .zero_result    (f_zero),
      .carry_flag     (f_carry),
      .half_flag      (f_half)
   );

   assign early_req = control_wr
                      && control_wdata[core_regs_pkg::CC_EARLY];

   loop_status_track #(
      .DEPTH_W (3)
   ) i_loop_status_track (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .loop_enter (loop_enter),
      .loop_leave (loop_leave),
      .iter_end   (loop_iter_end),
      .exit_req   (early_req),
      .depth      (nest_depth),
      .exit_now   (loop_early_exit)
   );

   // =====================================================
   // accumulator wrap flags: follow the latest dsp result
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc_a_wrap_flag_reg <= 1'b0;
         acc_b_wrap_flag_reg <= 1'b0;
      end else begin
         if (dsp_acc_a_update) begin
            acc_a_wrap_flag_reg <= dsp_acc_a_over;
         end else if (status_wr) begin
            acc_a_wrap_flag_reg <=
               status_wdata[core_regs_pkg::ST_WRAP_A];
         end
         if (dsp_acc_b_update) begin
            acc_b_wrap_flag_reg <= dsp_acc_b_over;
         end else if (status_wr) begin
            acc_b_wrap_flag_reg <=
               status_wdata[core_regs_pkg::ST_WRAP_B];
         end
      end
   end

   // software clearing bit 11 masks the combined wrap bit until the
   // next overflow event; the per-accumulator flags take bits 15 and 14 of the write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         any_wrap_clr_reg <= 1'b0;
      end else if ((dsp_acc_a_update && dsp_acc_a_over)
                   || (dsp_acc_b_update && dsp_acc_b_over)) begin
         any_wrap_clr_reg <= 1'b0;
      end else if (status_wr
                   && !status_wdata[core_regs_pkg::ST_ANY_WRAP]) begin
         any_wrap_clr_reg <= 1'b1;
      end
   end

   // =====================================================
   // sticky clip flags: saturation event wins over any write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         acc_a_clip_sticky_reg <= 1'b0;
         acc_b_clip_sticky_reg <= 1'b0;
      end else begin
         if (dsp_acc_a_sat) begin
            acc_a_clip_sticky_reg <= 1'b1;
         end else if (status_wr) begin
            acc_a_clip_sticky_reg <=
               status_wdata[core_regs_pkg::ST_CLIP_A]
               && status_wdata[core_regs_pkg::ST_ANY_CLIP];
         end
         if (dsp_acc_b_sat) begin
            acc_b_clip_sticky_reg <= 1'b1;
         end else if (status_wr) begin
            acc_b_clip_sticky_reg <=
               status_wdata[core_regs_pkg::ST_CLIP_B]
               && status_wdata[core_regs_pkg::ST_ANY_CLIP];
         end
      end
   end

   assign any_wrap = (acc_a_wrap_flag_reg || acc_b_wrap_flag_reg)
                     && !any_wrap_clr_reg;
   assign any_clip = acc_a_clip_sticky_reg
                     || acc_b_clip_sticky_reg;

   // =====================================================
   // alu flags: a result update wins over a software write
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         half_carry_flag_reg <= 1'b0;
         neg_reg             <= 1'b0;
         swrap_reg           <= 1'b0;
         carry_reg           <= 1'b0;
      end else if (alu_update) begin
         half_carry_flag_reg <= f_half;
         neg_reg             <= f_neg;
         swrap_reg           <= f_swrap;
         carry_reg           <= f_carry;
      end else if (status_wr) begin
         half_carry_flag_reg <= status_wdata[core_regs_pkg::ST_HALF_C];
         neg_reg             <= status_wdata[core_regs_pkg::ST_NEG];
         swrap_reg           <= status_wdata[core_regs_pkg::ST_SWRAP];
         carry_reg           <= status_wdata[core_regs_pkg::ST_CARRY];
      end
   end

   // zero never sets on a zero result; a non-zero result or a status write of 0 clears it
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         zero_reg <= 1'b0;
      end else if (alu_update) begin
         zero_reg <= zero_reg && f_zero;
      end else if (status_wr) begin
         zero_reg <= status_wdata[core_regs_pkg::ST_ZERO];
      end
   end

   // =====================================================
   // priority level, lower three bits and msb
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prio_reg <= 3'h0;
      end else if (prio_load) begin
         prio_reg <= prio_load_val[2:0];
      end else if (status_wr && !nesting_disable_ctl) begin
         prio_reg <= status_wdata[core_regs_pkg::ST_PRIO_HI:
                                  core_regs_pkg::ST_PRIO_LO];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prio_msb_reg <= 1'b0;
      end else if (prio_load) begin
         prio_msb_reg <= prio_load_val[3];
      end else if (control_wr
                   && !control_wdata[core_regs_pkg::CC_PRIO_MSB]) begin
         prio_msb_reg <= 1'b0;
      end
   end

   assign cpu_priority_level = {prio_msb_reg, prio_reg};
   assign user_irq_masked    = prio_msb_reg
                               || prio_reg == core_regs_pkg::PRIO_MASKED;

   // =====================================================
   // core control writable fields
   localparam logic [15:0] CTL_RST = core_regs_pkg::CONTROL_RESET;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         var_lat_reg    <= CTL_RST[core_regs_pkg::CC_VAR_LAT];
         mul_mode_reg   <= core_regs_pkg::MUL_SIGNED;
         clip_a_en_reg  <= CTL_RST[core_regs_pkg::CC_CLIP_A];
         clip_b_en_reg  <= CTL_RST[core_regs_pkg::CC_CLIP_B];
         clip_st_en_reg <= CTL_RST[core_regs_pkg::CC_CLIP_ST];
         clip_w_reg     <= CTL_RST[core_regs_pkg::CC_CLIP_W];
         round_reg      <= CTL_RST[core_regs_pkg::CC_ROUND];
         int_mul_reg    <= CTL_RST[core_regs_pkg::CC_INT_MUL];
      end else if (control_wr) begin
         var_lat_reg    <= control_wdata[core_regs_pkg::CC_VAR_LAT];
         mul_mode_reg   <= control_wdata[core_regs_pkg::CC_MUL_HI:
                                         core_regs_pkg::CC_MUL_LO];
         clip_a_en_reg  <= control_wdata[core_regs_pkg::CC_CLIP_A];
         clip_b_en_reg  <= control_wdata[core_regs_pkg::CC_CLIP_B];
         clip_st_en_reg <= control_wdata[core_regs_pkg::CC_CLIP_ST];
         clip_w_reg     <= control_wdata[core_regs_pkg::CC_CLIP_W];
         round_reg      <= control_wdata[core_regs_pkg::CC_ROUND];
         int_mul_reg    <= control_wdata[core_regs_pkg::CC_INT_MUL];
      end
   end

   assign var_latency_en      = var_lat_reg;
   assign multiply_sign_mode  = mul_mode_reg;
   assign mul_mode_reserved   =
      mul_mode_reg == core_regs_pkg::MUL_RESERVED;
   assign clip_enable_acc_a   = clip_a_en_reg;
   assign clip_enable_acc_b   = clip_b_en_reg;
   assign clip_enable_store   = clip_st_en_reg;
   assign clip_width_mode     = clip_w_reg;
   assign frame_window_active = frame_active_in;
   assign round_mode_sel      = round_reg;
   assign int_multiply_sel    = int_mul_reg;

   // =====================================================
   // read views
   always_comb begin
      status_rdata = 16'h0000;
      status_rdata[core_regs_pkg::ST_WRAP_A]   = acc_a_wrap_flag_reg;
      status_rdata[core_regs_pkg::ST_WRAP_B]   = acc_b_wrap_flag_reg;
      status_rdata[core_regs_pkg::ST_CLIP_A]   = acc_a_clip_sticky_reg;
      status_rdata[core_regs_pkg::ST_CLIP_B]   = acc_b_clip_sticky_reg;
      status_rdata[core_regs_pkg::ST_ANY_WRAP] = any_wrap;
      status_rdata[core_regs_pkg::ST_ANY_CLIP] = any_clip;
      status_rdata[core_regs_pkg::ST_LOOP]     = nest_depth != 3'h0;
      status_rdata[core_regs_pkg::ST_HALF_C]   = half_carry_flag_reg;
      status_rdata[core_regs_pkg::ST_PRIO_HI:
                   core_regs_pkg::ST_PRIO_LO]  = prio_reg;
      status_rdata[core_regs_pkg::ST_REPEAT]   = repeat_busy;
      status_rdata[core_regs_pkg::ST_NEG]      = neg_reg;
      status_rdata[core_regs_pkg::ST_SWRAP]    = swrap_reg;
      status_rdata[core_regs_pkg::ST_ZERO]     = zero_reg;
      status_rdata[core_regs_pkg::ST_CARRY]    = carry_reg;
   end

   // bit 14 and the early exit bit always read zero
   always_comb begin
      control_rdata = 16'h0000;
      control_rdata[core_regs_pkg::CC_VAR_LAT]  = var_lat_reg;
      control_rdata[core_regs_pkg::CC_MUL_HI:
                    core_regs_pkg::CC_MUL_LO]   = mul_mode_reg;
      control_rdata[core_regs_pkg::CC_DEPTH_HI:
                    core_regs_pkg::CC_DEPTH_LO] = nest_depth;
      control_rdata[core_regs_pkg::CC_CLIP_A]   = clip_a_en_reg;
      control_rdata[core_regs_pkg::CC_CLIP_B]   = clip_b_en_reg;
      control_rdata[core_regs_pkg::CC_CLIP_ST]  = clip_st_en_reg;
      control_rdata[core_regs_pkg::CC_CLIP_W]   = clip_w_reg;
      control_rdata[core_regs_pkg::CC_PRIO_MSB] = prio_msb_reg;
      control_rdata[core_regs_pkg::CC_FRAME]    = frame_active_in;
      control_rdata[core_regs_pkg::CC_ROUND]    = round_reg;
      control_rdata[core_regs_pkg::CC_INT_MUL]  = int_mul_reg;
   end
endmodule
`default_nettype wire

// ==== test/core_regs_checker.sv ====
// core_regs_checker: port assertions for the status and control words.
// assumes it is bound onto cpu_status_core_control_regs, one clock.
`timescale 1ns/1ps
`default_nettype none
module core_regs_checker (
   // clock and reset
   input wire logic        clk,
   input wire logic        sys_rst,
   // register views
   input wire logic [15:0] status_rdata,
   input wire logic [15:0] control_rdata,
   // events
   input wire logic        dsp_acc_a_update,
   input wire logic        dsp_acc_a_over,
   input wire logic        dsp_acc_a_sat,
   input wire logic        nesting_disable_ctl,
   input wire logic        prio_load,
   // priority
   input wire logic [3:0]  cpu_priority_level,
   input wire logic        user_irq_masked
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);

   // ==========================================
   // saturation steps
   sequence s_sat_a;
      dsp_acc_a_sat;
   endsequence
   sequence s_clip_a_shown;
      status_rdata[13] && status_rdata[10];
   endsequence

   a_clip_sticky: assert property (s_sat_a |=> s_clip_a_shown)
      else $error("clip flag a missing after saturation");
   a_wrap_follow: assert property (dsp_acc_a_update |=>
      status_rdata[15] == $past(dsp_acc_a_over))
      else $error("wrap flag a does not follow overflow");
   a_any_clip: assert property (
      status_rdata[10] == (status_rdata[13] || status_rdata[12]))
      else $error("combined clip bit wrong");
   a_loop_flag: assert property (
      status_rdata[9] == (control_rdata[10:8] != 3'h0))
      else $error("loop active flag disagrees with depth");
   a_prio_concat: assert property (
      cpu_priority_level == {control_rdata[3], status_rdata[7:5]})
      else $error("priority level not formed from both words");
   a_irq_mask: assert property (user_irq_masked ==
      (cpu_priority_level[3] || cpu_priority_level[2:0] == 3'h7))
      else $error("user interrupt mask wrong");
   a_prio_frozen: assert property (
      nesting_disable_ctl && !prio_load |=> $stable(status_rdata[7:5]))
      else $error("priority bits changed while frozen");
   a_reset_values: assert property ($fell(sys_rst) |->
      status_rdata[13:10] == 4'h0 && control_rdata[7:4] == 4'h2)
      else $error("reset values wrong");
endmodule

bind cpu_status_core_control_regs core_regs_checker i_core_regs_checker (
   .clk, .sys_rst, .status_rdata, .control_rdata, .dsp_acc_a_update,
   .dsp_acc_a_over, .dsp_acc_a_sat, .nesting_disable_ctl, .prio_load,
   .cpu_priority_level, .user_irq_masked);
`default_nettype wire

// ==== test/alu_model.sv ====
// alu_model: adder standing in for the core alu.
// assumes operands are held by the bench across each update.
`timescale 1ns/1ps
`default_nettype none
module alu_model (
   // operands
   input  wire logic        alu_byte_op,
   input  wire logic [15:0] alu_opnd_a,
   input  wire logic [15:0] alu_opnd_b,
   // results
   output logic [15:0]      alu_result,
   output logic             alu_carry_out,
   output logic             alu_half_carry_out
);
   wire logic [16:0] sum = {1'h0, alu_opnd_a} + {1'h0, alu_opnd_b};
   wire logic [8:0]  lo  = {1'h0, alu_opnd_a[7:0]} + {1'h0, alu_opnd_b[7:0]};
   wire logic [4:0]  nib = {1'h0, alu_opnd_a[3:0]} + {1'h0, alu_opnd_b[3:0]};
   assign alu_result = sum[15:0];
   // byte ops carry out of bit 7, so the upper byte is don't-care
   assign alu_carry_out = alu_byte_op ? lo[8] : sum[16];
   assign alu_half_carry_out = alu_byte_op ? nib[4] : lo[8];
endmodule
`default_nettype wire

// ==== test/cpu_status_core_control_regs_test.sv ====
// cpu_status_core_control_regs_test: self-checking bench for both words.
// assumes alu_model feeds the alu result and carry ports.
`timescale 1ns/1ps
`default_nettype none
module cpu_status_core_control_regs_test;
   typedef struct packed {
      logic [15:0] a, b;
      logic        bo;
      logic [15:0] exp;
   } row_t;
   // ==========================================
   // signals
   logic        clk = '0, sys_rst = '1, status_wr = '0, control_wr = '0;
   logic        alu_update = '0, alu_byte_op = '0, alu_carry_out;
   logic        alu_half_carry_out, repeat_busy = '0, loop_enter = '0;
   logic        loop_leave = '0, loop_iter_end = '0, frame_active_in = '0;
   logic        dsp_acc_a_update = '0, dsp_acc_a_over = '0;
   logic        dsp_acc_b_update = '0, dsp_acc_b_over = '0;
   logic        dsp_acc_a_sat = '0, dsp_acc_b_sat = '0, prio_load = '0;
   logic        nesting_disable_ctl = '0, mul_mode_reserved, loop_early_exit;
   logic        user_irq_masked;
   logic [1:0]  multiply_sign_mode;
   logic [7:0]  ctl_out;
   logic [3:0]  prio_load_val = '0, cpu_priority_level;
   logic [15:0] status_wdata = '0, control_wdata = '0, alu_opnd_a = '0;
   logic [15:0] alu_opnd_b = '0, alu_result, status_rdata, control_rdata;
   int          error_cnt = 0, check_count = 0;
   row_t        rows [4] = '{'{16'h7fff, 16'h0001, 1'h0, 16'h010c},
                             '{16'hffff, 16'h0001, 1'h0, 16'h0101},
                             '{16'h000f, 16'h0001, 1'h1, 16'h0100},
                             '{16'h0080, 16'h0080, 1'h1, 16'h0005}};

   cpu_status_core_control_regs i_cpu_status_core_control_regs (
      .clk, .sys_rst, .status_wr, .status_wdata, .status_rdata, .control_wr,
      .control_wdata, .control_rdata, .alu_update, .alu_byte_op, .alu_opnd_a,
      .alu_opnd_b, .alu_result, .alu_carry_out, .alu_half_carry_out,
      .dsp_acc_a_update, .dsp_acc_a_over, .dsp_acc_a_sat, .dsp_acc_b_update,
      .dsp_acc_b_over, .dsp_acc_b_sat, .repeat_busy, .loop_enter, .loop_leave,
      .loop_iter_end, .frame_active_in, .nesting_disable_ctl, .prio_load,
      .prio_load_val, .var_latency_en(ctl_out[7]), .multiply_sign_mode,
      .mul_mode_reserved, .loop_early_exit, .clip_enable_acc_a(ctl_out[6]),
      .clip_enable_acc_b(ctl_out[5]), .clip_enable_store(ctl_out[4]),
      .clip_width_mode(ctl_out[3]), .frame_window_active(ctl_out[2]),
      .round_mode_sel(ctl_out[1]), .int_multiply_sel(ctl_out[0]),
      .cpu_priority_level, .user_irq_masked);
   alu_model i_alu_model (.alu_byte_op, .alu_opnd_a, .alu_opnd_b,
      .alu_result, .alu_carry_out, .alu_half_carry_out);

   always #2 clk = ~clk;

   // ==========================================
   // helpers
   // every pulse drops at the next falling edge, so one call is one cycle
   task automatic nx();
      @(negedge clk);
      {status_wr, control_wr, alu_update, dsp_acc_a_update, dsp_acc_a_sat,
       dsp_acc_b_update, dsp_acc_b_sat, loop_enter, loop_leave,
       loop_iter_end, prio_load} = '0;
   endtask
   task automatic wst(input logic [15:0] d);
      {status_wr, status_wdata} = {1'h1, d};
      nx();
   endtask
   task automatic wct(input logic [15:0] d);
      {control_wr, control_wdata} = {1'h1, d};
      nx();
   endtask
   task automatic alu(input logic [15:0] a, input logic [15:0] b,
                      input logic bo);
      {alu_update, alu_opnd_a, alu_opnd_b, alu_byte_op} = {1'h1, a, b, bo};
      nx();
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================
   // sequence
   initial begin
      #100000 error_cnt++;
      stop_test();
   end

   initial begin
      repeat (4) @(posedge clk);
      @(negedge clk) sys_rst = '0;
      chk(status_rdata, 16'h0000);
      chk(control_rdata, 16'h0020);
      foreach (rows[i]) begin
         alu(rows[i].a, rows[i].b, rows[i].bo);
         chk(status_rdata, rows[i].exp);
      end
      wst(16'h0002);
      alu(16'h0000, 16'h0000, 1'h0);
      chk(status_rdata, 16'h0002);
      alu(16'h0001, 16'h0001, 1'h0);
      chk(status_rdata, 16'h0000);
      {dsp_acc_a_update, dsp_acc_a_over, dsp_acc_b_sat} = 3'h7;
      nx();
      chk(status_rdata, 16'h9c00);
      {dsp_acc_a_update, dsp_acc_a_over, dsp_acc_a_sat} = 3'h5;
      {dsp_acc_b_update, dsp_acc_b_over} = 2'h3;
      nx();
      chk(status_rdata, 16'h7c00);
      wst(16'h2000);
      chk(status_rdata, 16'h0000);
      wst(16'h1400);
      chk(status_rdata, 16'h1400);
      wct(16'hffff);
      chk(control_rdata, 16'hb0f3);
      chk({8'h0, ctl_out}, 16'h00fb);
      for (int m = 0; m < 4; m++) begin
         wct({2'h0, m[1:0], 12'h020});
         chk({14'h0, multiply_sign_mode}, 16'(m));
         chk({15'h0, mul_mode_reserved}, 16'(m == 3));
      end
      loop_enter = '1;
      nx();
      loop_enter = '1;
      nx();
      chk({12'h0, status_rdata[9], control_rdata[10:8]}, 16'h000a);
      wct(16'h0820);
      loop_iter_end = '1;
      #1 chk({15'h0, loop_early_exit}, 16'h0001);
      nx();
      loop_leave = '1;
      nx();
      loop_leave = '1;
      nx();
      chk({12'h0, status_rdata[9], control_rdata[10:8]}, 16'h0000);
      {prio_load, prio_load_val} = 5'h1f;
      nx();
      chk({11'h0, user_irq_masked, cpu_priority_level}, 16'h001f);
      nesting_disable_ctl = '1;
      wst(16'h0000);
      chk(status_rdata, 16'h00e0);
      nesting_disable_ctl = '0;
      wct(16'h0020);
      chk({11'h0, user_irq_masked, cpu_priority_level}, 16'h0017);
      wst(16'h0000);
      chk({11'h0, user_irq_masked, cpu_priority_level}, 16'h0000);
      {repeat_busy, frame_active_in} = 2'h3;
      #1 chk(status_rdata, 16'h0010);
      chk(control_rdata, 16'h0024);
      wct(16'h0000);
      sys_rst = '1;
      nx();
      sys_rst = '0;
      chk(control_rdata, 16'h0024);
      chk({8'h0, ctl_out}, 16'h0014);
      stop_test();
   end
endmodule
`default_nettype wire
